// ==== core/iposq_regs.svh ====
// Register map, reset values and timing constants of the input power-up sequencer
// Contract
// - Qualify VBUS under test load before converter start
// - Retry qualification after overvoltage clears
// - Seven bad-source failures set high-impedance mode
// - Replug or bit toggle exits; insertion clears bit
// - Detect source only after qualification, if enabled
// - Load current limit; restore voltage limit if enabled
// - Update type, power-good, pin, interrupt pulse
// - Input current never exceeds field or pin
// - Detection disabled: skip, keep limit, type 000
// - Detection order: VBUS, contact, primary, secondary
// - Forced detection reruns; bit clears when done
// - Regulator on after conditions hold 50ms
// - Power-good asserted before converter switching
// - Battery switch follows charge enable after power-up
// - Discharge probe 13ms before charging; bit forces (probe runs from run entry, battery switch not held off)
// - Light load PFM when charging off or battery low, unless disabled
// - PFM audio band avoidance unless disabled
// - Optimizer on at reset, auto after DCP, forceable
// - Effective limit from optimizer or field, pin
// - Seed optimizer from field or minimum code
// - Voltage trigger reduces result, then done flag
// - Low battery: hold seed, current trigger completes
`ifndef IPOSQ_REGS_SVH
`define IPOSQ_REGS_SVH
`define IPOSQ_CTRL_OFF     4'h0
`define IPOSQ_LIM_OFF      4'h4
`define IPOSQ_STAT_OFF     4'h8
`define IPOSQ_EFF_OFF      4'hC
`define IPOSQ_CTRL_RST     11'h506
`define IPOSQ_EXTERNAL_CURRENT_LIMIT_PIN_RST     5'h04
`define IPOSQ_VLIM_RST     5'h0A
`define IPOSQ_LIM_SDP      5'h04
`define IPOSQ_LIM_CDP      5'h0F
`define IPOSQ_LIM_DCP      5'h13
`define IPOSQ_LIM_NSTD     5'h09
`define IPOSQ_ICO_MIN      5'h04
`define IPOSQ_FAIL_MAX     3'h7
`define IPOSQ_CLK_NS       5
`define IPOSQ_NS_PER_MS    1000000
`define IPOSQ_NS_PER_US    1000
`define IPOSQ_QUAL_MS      30
`define IPOSQ_INTERNAL_BIAS_REGULATOR_MS      50
`define IPOSQ_PROBE_MS     13
`define IPOSQ_STEP_US      100
`define IPOSQ_SETTLE_US    1000
`define IPOSQ_INT_NS       1000
`endif

// ==== core/iposq_pkg.sv ====
// Types shared by the input power-up sequencer
package iposq_pkg;
  typedef enum logic [2:0] {SRC_NONE = 3'h0, SRC_SDP = 3'h1, SRC_CDP = 3'h2,
                            SRC_DCP = 3'h3, SRC_NSTD = 3'h4} iposq_src_type;
  typedef enum logic [1:0] {ICO_OFF = 2'h0, ICO_RUN = 2'h1,
                            ICO_DONE = 2'h2} iposq_ico_type;
  typedef enum {ST_IDLE, ST_QUAL, ST_OVP, ST_HIZ, ST_VBDET, ST_DCD, ST_PRIM,
                ST_SEC, ST_REGWAIT, ST_RUN} iposq_state_type;
  typedef struct packed {
    logic chargeEnable;
    logic optimizerForce;
    logic optimizerEnable;
    logic audioAvoidDisable;
    logic lightLoadPulseModeDisable;
    logic batteryDischargeLoadEnable;
    logic externalLimitEnable;
    logic forcedSourceDetect;
    logic voltageLimitRestoreEnable;
    logic autoSourceDetectEnable;
    logic highImpedanceEnable;
  } iposq_ctrl_type;
  typedef struct packed {
    logic [4:0] inputVoltageLimitField;
    logic [2:0] spare;
    logic [4:0] inputCurrentLimitField;
  } iposq_lim_type;
  typedef struct packed {
    logic          converterOn;
    logic          regulatorOn;
    logic [2:0]    failCount;
    logic [4:0]    optimizerResultLimit;
    logic          optimizerFlag;
    iposq_ico_type optimizerStatus;
    logic          powerGoodFlag;
    logic          powerGoodStatus;
    iposq_src_type sourceTypeStatus;
  } iposq_stat_type;
endpackage

// ==== core/iposq_top.sv ====
// Input qualification, source detection, power-up and optimizer sequencer
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "iposq_regs.svh"
module iposq_top #(
  parameter int QUAL_CYC   = `IPOSQ_QUAL_MS * `IPOSQ_NS_PER_MS / `IPOSQ_CLK_NS,
  parameter int INTERNAL_BIAS_REGULATOR_CYC   = `IPOSQ_INTERNAL_BIAS_REGULATOR_MS * `IPOSQ_NS_PER_MS / `IPOSQ_CLK_NS,
  parameter int PROBE_CYC  = `IPOSQ_PROBE_MS * `IPOSQ_NS_PER_MS / `IPOSQ_CLK_NS,
  parameter int STEP_CYC   = `IPOSQ_STEP_US * `IPOSQ_NS_PER_US / `IPOSQ_CLK_NS,
  parameter int SETTLE_CYC = `IPOSQ_SETTLE_US * `IPOSQ_NS_PER_US / `IPOSQ_CLK_NS
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       s_axi_awvalid,
  output logic            s_axi_awready,
  input  wire logic [3:0] s_axi_awaddr,
  input  wire logic       s_axi_wvalid,
  output logic            s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0] s_axi_wstrb,
  output logic            s_axi_bvalid,
  input  wire logic       s_axi_bready,
  output logic [1:0]      s_axi_bresp,
  input  wire logic       s_axi_arvalid,
  output logic            s_axi_arready,
  input  wire logic [3:0] s_axi_araddr,
  output logic            s_axi_rvalid,
  input  wire logic       s_axi_rready,
  output logic [31:0]     s_axi_rdata,
  output logic [1:0]      s_axi_rresp,
  input  wire logic       vbusAboveUvlo,
  input  wire logic       vbusOverVolt,
  input  wire logic       vbusAboveBadSrc,
  input  wire logic       dataContact,
  input  wire logic       primaryHit,
  input  wire logic       secondaryDcp,
  input  wire logic [4:0] external_current_limit_pin,
  input  wire logic       vbatBelowMinSys,
  input  wire logic       lightLoad,
  input  wire logic       vindpmHit,
  input  wire logic       iindpmHit,
  output logic            qualLoadOn,
  output logic            high_impedance_mode,
  output logic            internal_bias_regulator,
  output logic            converterOn,
  output logic            battery_switch,
  output logic            dischargeLoadOn,
  output logic            pfmOn,
  output logic            audio_band_avoidance,
  output logic [4:0]      effLimit,
  output logic            power_good_n_pin,
  output logic            interrupt_n_pin
);
  localparam int TW = 24;
  localparam int INT_CYC = `IPOSQ_INT_NS / `IPOSQ_CLK_NS;

  iposq_pkg::iposq_state_type state_r, state_nxt;
  iposq_pkg::iposq_ctrl_type  ctrl_r;
  iposq_pkg::iposq_lim_type   lim_r;
  iposq_pkg::iposq_src_type   src_r, detSrc;
  iposq_pkg::iposq_ico_type   icoStat_r;
  iposq_pkg::iposq_stat_type  stat;
  logic [TW-1:0] tmr_r, probe_r, icoTmr_r;
  logic [7:0]    intCnt_r;
  logic [2:0]    fail_r;
  logic [4:0]    icoRes_r, baseLim, limA;
  logic [3:0]    awAddr_r;
  logic [31:0]   wData_r, wMask, rdata;
  logic          awHeld_r, wHeld_r, doWrite, rdHit, statRead, wrOk;
  logic          vbusPrev_r, insert, running_r, pg_r, pgFlag_r, icoFlag_r;
  logic          qualFail, qualPass, detDone, stepEnd, pgSet, intEv;
  logic          icoStart, icoDoneEv, backedOff_r, icoTick, limWrite, icoPend_r;

  // Byte enables to a bit mask
  function automatic logic [31:0] strbMask(input logic [3:0] s);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{s[i]}};
    end
    return m;
  endfunction

  // Current limit per detected source type
  function automatic logic [4:0] srcLimit(input iposq_pkg::iposq_src_type s);
    case (s)
      iposq_pkg::SRC_SDP: return `IPOSQ_LIM_SDP;
      iposq_pkg::SRC_CDP: return `IPOSQ_LIM_CDP;
      iposq_pkg::SRC_DCP: return `IPOSQ_LIM_DCP;
      default:            return `IPOSQ_LIM_NSTD;
    endcase
  endfunction

  // Write channel capture, either order
  assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld_r && !s_axi_bvalid;
  assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
  assign wMask = strbMask(s_axi_wstrb);
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      awHeld_r <= 1'b0;
      wHeld_r  <= 1'b0;
      awAddr_r <= 4'h0;
      wData_r  <= 32'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= (s_axi_wdata & wMask) | (wData_r & ~wMask);
      end else if (doWrite) begin
        wHeld_r <= 1'b0;
      end
    end
  end

  // Write response, error on unmapped or read-only address
  assign wrOk = awAddr_r == `IPOSQ_CTRL_OFF || awAddr_r == `IPOSQ_LIM_OFF;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wrOk ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read path
  assign s_axi_arready = !s_axi_rvalid;
  assign rdHit = s_axi_arvalid && s_axi_arready;
  assign statRead = rdHit && s_axi_araddr == `IPOSQ_STAT_OFF;
  assign stat = '{converterOn: state_r == iposq_pkg::ST_RUN,
                  regulatorOn: running_r, failCount: fail_r,
                  optimizerResultLimit: icoRes_r, optimizerFlag: icoFlag_r,
                  optimizerStatus: icoStat_r, powerGoodFlag: pgFlag_r,
                  powerGoodStatus: pg_r, sourceTypeStatus: src_r};
  always_comb begin
    rdata = 32'h0;
    if (s_axi_araddr == `IPOSQ_CTRL_OFF) begin
      rdata = 32'(ctrl_r);
    end else if (s_axi_araddr == `IPOSQ_LIM_OFF) begin
      rdata = 32'(lim_r);
    end else if (s_axi_araddr == `IPOSQ_STAT_OFF) begin
      rdata = 32'(stat);
    end else if (s_axi_araddr == `IPOSQ_EFF_OFF) begin
      rdata = 32'(effLimit);
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= 2'h0;
    end else if (rdHit) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdata;
      s_axi_rresp  <= s_axi_araddr[1:0] == 2'h0 ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Sequencer next state
  assign insert = vbusAboveUvlo && !vbusPrev_r;
  assign stepEnd = tmr_r == TW'(STEP_CYC - 1);
  always_comb begin
    state_nxt = state_r;
    qualFail = 1'b0;
    qualPass = 1'b0;
    detDone = 1'b0;
    detSrc = iposq_pkg::SRC_NONE;
    if (!vbusAboveUvlo) begin
      state_nxt = iposq_pkg::ST_IDLE;
    end else if (vbusOverVolt) begin
      state_nxt = iposq_pkg::ST_OVP;
    end else if (ctrl_r.highImpedanceEnable && state_r != iposq_pkg::ST_IDLE) begin
      state_nxt = iposq_pkg::ST_HIZ;
    end else begin
      case (state_r)
        iposq_pkg::ST_IDLE: state_nxt = iposq_pkg::ST_QUAL;
        iposq_pkg::ST_OVP:  state_nxt = iposq_pkg::ST_QUAL;
        iposq_pkg::ST_HIZ:  state_nxt = iposq_pkg::ST_QUAL;
        iposq_pkg::ST_QUAL: begin
          if (!vbusAboveBadSrc) begin
            qualFail = 1'b1;
            if (fail_r == `IPOSQ_FAIL_MAX - 3'h1) begin
              state_nxt = iposq_pkg::ST_HIZ;
            end
          end else if (tmr_r == TW'(QUAL_CYC - 1)) begin
            qualPass = 1'b1;
            state_nxt = ctrl_r.autoSourceDetectEnable ? iposq_pkg::ST_VBDET
                                                      : iposq_pkg::ST_REGWAIT;
          end
        end
        iposq_pkg::ST_VBDET: begin
          if (stepEnd) begin
            state_nxt = iposq_pkg::ST_DCD;
          end
        end
        iposq_pkg::ST_DCD: begin
          if (stepEnd && !dataContact) begin
            detDone = 1'b1;
            detSrc = iposq_pkg::SRC_NSTD;
          end else if (stepEnd) begin
            state_nxt = iposq_pkg::ST_PRIM;
          end
        end
        iposq_pkg::ST_PRIM: begin
          if (stepEnd && !primaryHit) begin
            detDone = 1'b1;
            detSrc = iposq_pkg::SRC_SDP;
          end else if (stepEnd) begin
            state_nxt = iposq_pkg::ST_SEC;
          end
        end
        iposq_pkg::ST_SEC: begin
          if (stepEnd) begin
            detDone = 1'b1;
            detSrc = secondaryDcp ? iposq_pkg::SRC_DCP : iposq_pkg::SRC_CDP;
          end
        end
        iposq_pkg::ST_REGWAIT: begin
          if (tmr_r == TW'(INTERNAL_BIAS_REGULATOR_CYC - 1)) begin
            state_nxt = iposq_pkg::ST_RUN;
          end
        end
        default: begin
          if (ctrl_r.forcedSourceDetect) begin
            state_nxt = iposq_pkg::ST_VBDET;
          end
        end
      endcase
      if (detDone) begin
        state_nxt = running_r ? iposq_pkg::ST_RUN : iposq_pkg::ST_REGWAIT;
      end
    end
  end

  // Sequencer state, step timer and power-up memory
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r    <= iposq_pkg::ST_IDLE;
      tmr_r      <= '0;
      vbusPrev_r <= 1'b0;
      running_r  <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      vbusPrev_r <= vbusAboveUvlo;
      tmr_r      <= (state_nxt != state_r || qualFail) ? '0 : tmr_r + 1'b1;
      if (state_nxt == iposq_pkg::ST_RUN) begin
        running_r <= 1'b1;
      end else if (state_nxt inside {iposq_pkg::ST_IDLE, iposq_pkg::ST_OVP,
                                     iposq_pkg::ST_HIZ, iposq_pkg::ST_QUAL}) begin
        running_r <= 1'b0;
      end
    end
  end

  // Consecutive bad-source failures
  always_ff @(posedge clk) begin
    if (!rst_b || qualPass || !vbusAboveUvlo) begin
      fail_r <= 3'h0;
    end else if (state_r == iposq_pkg::ST_HIZ && state_nxt == iposq_pkg::ST_QUAL) begin
      fail_r <= 3'h0;
    end else if (qualFail) begin
      fail_r <= fail_r + 3'h1;
    end
  end

  // Control register; hardware updates win over a same-cycle write
  assign limWrite = doWrite && awAddr_r == `IPOSQ_LIM_OFF;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_r <= `IPOSQ_CTRL_RST;
    end else begin
      if (doWrite && awAddr_r == `IPOSQ_CTRL_OFF) begin
        ctrl_r <= wData_r[$bits(ctrl_r)-1:0];
      end
      if (insert) begin
        ctrl_r.highImpedanceEnable <= 1'b0;
      end else if (qualFail && state_nxt == iposq_pkg::ST_HIZ) begin
        ctrl_r.highImpedanceEnable <= 1'b1;
      end
      if (detDone) begin
        ctrl_r.forcedSourceDetect <= 1'b0;
      end
      if (icoStart) begin
        ctrl_r.optimizerForce <= 1'b0;
      end
    end
  end

  // Limit fields; detection result overrides a write
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lim_r <= '{inputVoltageLimitField: `IPOSQ_VLIM_RST, spare: 3'h0,
                 inputCurrentLimitField: `IPOSQ_EXTERNAL_CURRENT_LIMIT_PIN_RST};
    end else begin
      if (limWrite) begin
        lim_r.inputVoltageLimitField <= wData_r[12:8];
        lim_r.inputCurrentLimitField <= wData_r[4:0];
      end
      if (detDone) begin
        lim_r.inputCurrentLimitField <= srcLimit(detSrc);
        if (ctrl_r.voltageLimitRestoreEnable) begin
          lim_r.inputVoltageLimitField <= `IPOSQ_VLIM_RST;
        end
      end
    end
  end

  // Source type and power-good; flag clear on status read, set wins
  assign pgSet = detDone || (qualPass && !ctrl_r.autoSourceDetectEnable);
  always_ff @(posedge clk) begin
    if (!rst_b || !vbusAboveUvlo) begin
      src_r <= iposq_pkg::SRC_NONE;
      pg_r  <= 1'b0;
    end else begin
      if (detDone) begin
        src_r <= detSrc;
      end else if (qualPass && !ctrl_r.autoSourceDetectEnable) begin
        src_r <= iposq_pkg::SRC_NONE;
      end
      if (pgSet) begin
        pg_r <= 1'b1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pgFlag_r <= 1'b0;
    end else if (pgSet) begin
      pgFlag_r <= 1'b1;
    end else if (statRead) begin
      pgFlag_r <= 1'b0;
    end
  end

  // Interrupt pulse; events during a pulse merge into it
  assign intEv = detDone || pgSet || (qualFail && state_nxt == iposq_pkg::ST_HIZ)
               || icoDoneEv;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      intCnt_r <= 8'h00;
    end else if (intCnt_r != 8'h00) begin
      intCnt_r <= intCnt_r - 8'h01;
    end else if (intEv) begin
      intCnt_r <= 8'(INT_CYC);
    end
  end

  // Battery presence probe on entry to run
  always_ff @(posedge clk) begin
    if (!rst_b || state_r != iposq_pkg::ST_RUN) begin
      probe_r <= '0;
    end else if (probe_r != TW'(PROBE_CYC)) begin
      probe_r <= probe_r + 1'b1;
    end
  end

  // DCP found before power-up: start the optimizer once running
  always_ff @(posedge clk) begin
    if (!rst_b || !vbusAboveUvlo || icoStart) begin
      icoPend_r <= 1'b0;
    end else if (detDone && detSrc == iposq_pkg::SRC_DCP) begin
      icoPend_r <= 1'b1;
    end
  end

  // Optimizer
  assign icoStart = ctrl_r.optimizerEnable && running_r
                    && ((detDone && detSrc == iposq_pkg::SRC_DCP)
                        || icoPend_r || ctrl_r.optimizerForce || limWrite);
  assign icoTick = icoTmr_r == TW'(SETTLE_CYC - 1);
  always_comb begin
    icoDoneEv = 1'b0;
    if (icoStat_r == iposq_pkg::ICO_RUN && ctrl_r.optimizerEnable && running_r
        && !icoStart && !vindpmHit && icoTick) begin
      icoDoneEv = backedOff_r || (iindpmHit && (vbatBelowMinSys
                  || icoRes_r >= lim_r.inputCurrentLimitField));
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b || !ctrl_r.optimizerEnable || !running_r) begin
      icoStat_r   <= iposq_pkg::ICO_OFF;
      icoRes_r    <= `IPOSQ_ICO_MIN;
      icoTmr_r    <= '0;
      backedOff_r <= 1'b0;
    end else if (icoStart) begin
      icoStat_r   <= iposq_pkg::ICO_RUN;
      icoRes_r    <= vbatBelowMinSys ? lim_r.inputCurrentLimitField
                                     : `IPOSQ_ICO_MIN;
      icoTmr_r    <= '0;
      backedOff_r <= 1'b0;
    end else if (icoStat_r == iposq_pkg::ICO_RUN) begin
      icoTmr_r <= (vindpmHit || icoTick) ? '0 : icoTmr_r + 1'b1;
      if (vindpmHit) begin
        backedOff_r <= 1'b1;
        if (icoRes_r > `IPOSQ_ICO_MIN) begin
          icoRes_r <= icoRes_r - 5'h01;
        end
      end else if (icoDoneEv) begin
        icoStat_r <= iposq_pkg::ICO_DONE;
      end else if (icoTick && iindpmHit) begin
        icoRes_r <= icoRes_r + 5'h01;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      icoFlag_r <= 1'b0;
    end else if (icoDoneEv) begin
      icoFlag_r <= 1'b1;
    end else if (statRead) begin
      icoFlag_r <= 1'b0;
    end
  end

  // Effective input current limit
  assign baseLim = icoStat_r != iposq_pkg::ICO_OFF ? icoRes_r
                                                   : lim_r.inputCurrentLimitField;
  assign limA = baseLim < lim_r.inputCurrentLimitField ? baseLim
                                                       : lim_r.inputCurrentLimitField;

  // Registered pin and control outputs
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      qualLoadOn              <= 1'b0;
      high_impedance_mode     <= 1'b1;
      internal_bias_regulator <= 1'b0;
      converterOn             <= 1'b0;
      battery_switch          <= 1'b1;
      dischargeLoadOn         <= 1'b0;
      pfmOn                   <= 1'b0;
      audio_band_avoidance    <= 1'b0;
      effLimit                <= `IPOSQ_EXTERNAL_CURRENT_LIMIT_PIN_RST;
      power_good_n_pin        <= 1'b1;
      interrupt_n_pin         <= 1'b1;
    end else begin
      qualLoadOn              <= state_r == iposq_pkg::ST_QUAL;
      high_impedance_mode     <= !running_r;
      internal_bias_regulator <= running_r;
      converterOn             <= running_r && pg_r;
      battery_switch          <= !running_r || ctrl_r.chargeEnable;
      dischargeLoadOn         <= ctrl_r.batteryDischargeLoadEnable
                                 || (running_r && probe_r != TW'(PROBE_CYC));
      pfmOn                   <= running_r && lightLoad
                                 && (!ctrl_r.chargeEnable || vbatBelowMinSys)
                                 && !ctrl_r.lightLoadPulseModeDisable;
      audio_band_avoidance    <= running_r && lightLoad
                                 && (!ctrl_r.chargeEnable || vbatBelowMinSys)
                                 && !ctrl_r.lightLoadPulseModeDisable
                                 && !ctrl_r.audioAvoidDisable;
      effLimit                <= (ctrl_r.externalLimitEnable
                                  && external_current_limit_pin < limA)
                                 ? external_current_limit_pin : limA;
      power_good_n_pin        <= !pg_r;
      interrupt_n_pin         <= intCnt_r == 8'h00;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_qual_fail_hiz: assert property (qualFail && fail_r == 3'h6 |=>
    state_r == iposq_pkg::ST_HIZ && ctrl_r.highImpedanceEnable)
    else $error("seventh failure did not enter high impedance");
  a_insert_clear: assert property (insert |=> !ctrl_r.highImpedanceEnable)
    else $error("insertion did not clear high impedance bit");
  a_skip_detect: assert property (qualPass && !ctrl_r.autoSourceDetectEnable
    |=> state_r == iposq_pkg::ST_REGWAIT && src_r == iposq_pkg::SRC_NONE)
    else $error("disabled detection not skipped");
  a_det_update: assert property (detDone |=> src_r == $past(detSrc) && pg_r
    ##1 !power_good_n_pin)
    else $error("detection completion did not update status");
  a_force_clear: assert property (detDone |=> !ctrl_r.forcedSourceDetect)
    else $error("forced detection bit not cleared");
  a_reg_wait: assert property ($rose(running_r) |->
    $past(state_r) == iposq_pkg::ST_REGWAIT && $past(tmr_r) == TW'(INTERNAL_BIAS_REGULATOR_CYC - 1))
    else $error("regulator enabled before hold time");
  a_eff_limit: assert property (##1 effLimit <= $past(lim_r.inputCurrentLimitField))
    else $error("effective limit above current field");
  a_int_pulse: assert property ($fell(interrupt_n_pin) |->
    !interrupt_n_pin [*8])
    else $error("interrupt pulse too short");
  a_ico_done: assert property (icoDoneEv |=>
    icoStat_r == iposq_pkg::ICO_DONE && icoFlag_r)
    else $error("optimizer completion not reported");
  a_seq_order: assert property (state_r == iposq_pkg::ST_PRIM |->
    $past(state_r) inside {iposq_pkg::ST_PRIM, iposq_pkg::ST_DCD})
    else $error("primary detection out of order");

  c_reach_run: cover property (state_r == iposq_pkg::ST_RUN);
  c_hiz_entry: cover property (qualFail && state_nxt == iposq_pkg::ST_HIZ);
  c_dcp_ico:   cover property (icoDoneEv && src_r == iposq_pkg::SRC_DCP);
endmodule

// ==== tb/iposq_adaptor.sv ====
// Adaptor model: VBUS presence, source quality and D+/D- answers
`timescale 1ns/1ps
module iposq_adaptor (
  input  wire logic       plugged,
  input  wire logic       good,
  input  wire logic [1:0] kind,
  output logic            vbusAboveUvlo,
  output logic            vbusAboveBadSrc,
  output logic            dataContact,
  output logic            primaryHit,
  output logic            secondaryDcp
);
  // Kind 0 SDP, 1 non-standard, 2 CDP, 3 DCP
  assign vbusAboveUvlo   = plugged;
  assign vbusAboveBadSrc = plugged & good;
  assign dataContact     = kind != 2'h1;
  assign primaryHit      = kind[1];
  assign secondaryDcp    = kind[0];
endmodule

// ==== tb/tb_top.sv ====
// Bench: detection table, disabled detection, bad-source lockout, bus errors
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0, rst_b = 1'b0, plugged = 1'b0, good = 1'b1, sawInt = 1'b0;
  logic [1:0] kind = 2'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdData;
  logic [1:0] s_axi_bresp, s_axi_rresp, rdResp, wrResp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic vbusAboveUvlo, vbusAboveBadSrc, dataContact, primaryHit, secondaryDcp;
  logic vbusOverVolt = 1'b0, vbatBelowMinSys = 1'b0, lightLoad = 1'b0;
  logic vindpmHit = 1'b0, iindpmHit = 1'b0;
  logic [4:0] external_current_limit_pin = 5'h1F, effLimit;
  logic qualLoadOn, high_impedance_mode, internal_bias_regulator, converterOn;
  logic battery_switch, dischargeLoadOn, pfmOn, audio_band_avoidance;
  logic power_good_n_pin, interrupt_n_pin;
  int num_errors = 0, n_tests = 0;
  logic [2:0] expType [4] = '{3'h1, 3'h4, 3'h2, 3'h3};
  logic [4:0] expLim [4] = '{5'h04, 5'h09, 5'h0F, 5'h13};
  logic [1:0] expIco [4] = '{2'h0, 2'h0, 2'h0, 2'h1};
  iposq_top #(.QUAL_CYC(40), .INTERNAL_BIAS_REGULATOR_CYC(60), .PROBE_CYC(20), .STEP_CYC(8), .SETTLE_CYC(10))
    i_iposq_top (.*);
  iposq_adaptor i_iposq_adaptor (.*);
  // Clock and interrupt pulse monitor
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) if (interrupt_n_pin === 1'b0) sawInt <= 1'b1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Bus write: both channels offered, each held until taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin do @(posedge clk); while (s_axi_awready !== 1'b1); s_axi_awvalid <= 1'b0; end
      begin do @(posedge clk); while (s_axi_wready !== 1'b1); s_axi_wvalid <= 1'b0; end
    join
    while (s_axi_bvalid !== 1'b1) @(posedge clk);
    wrResp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clk);
    rdData = s_axi_rdata;
    rdResp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Plug, then wait for switching under a bound
  task automatic plugIn(input logic [1:0] k);
    @(posedge clk);
    kind <= k;
    plugged <= 1'b1;
    for (int i = 0; i < 400 && converterOn !== 1'b1; i++) @(posedge clk);
  endtask
  task automatic unplug;
    @(posedge clk);
    plugged <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 300 && interrupt_n_pin !== 1'b1; i++) @(posedge clk);
  endtask
  task automatic stop_test;
    if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    stop_test;
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rd(4'h0);
    chk(rdData, 32'h506);
    chk(effLimit, 5'h04);
    for (int r = 0; r < 4; r++) begin
      sawInt = 1'b0;
      plugIn(2'(r));
      chk(power_good_n_pin, 1'b0);
      chk(sawInt, 1'b1);
      chk({high_impedance_mode, battery_switch, dischargeLoadOn}, 3'b011);
      rd(4'h8);
      chk(rdData[3:0], {1'b1, expType[r]});
      chk(rdData[6:5], expIco[r]);
      rd(4'h4);
      chk(rdData[4:0], expLim[r]);
      unplug;
    end
    // Detection off: type stays none, limit kept
    wr(4'h0, 32'h504);
    plugIn(2'h2);
    rd(4'h8);
    chk(rdData[3:0], 4'h8);
    rd(4'h4);
    chk(rdData[4:0], 5'h13);
    unplug;
    // Bad source locks out, replug recovers
    good <= 1'b0;
    plugIn(2'h0);
    rd(4'h0);
    chk(rdData[0], 1'b1);
    chk({internal_bias_regulator, high_impedance_mode}, 2'b01);
    unplug;
    good <= 1'b1;
    plugIn(2'h0);
    chk(converterOn, 1'b1);
    // Charging off, light load, pin limit below the field
    external_current_limit_pin <= 5'h02;
    wr(4'h0, 32'h114);
    lightLoad <= 1'b1;
    repeat (20) @(posedge clk);
    chk({pfmOn, audio_band_avoidance, battery_switch, dischargeLoadOn}, 4'hC);
    chk(effLimit, 5'h02);
    // Overvoltage stops switching, clearing it requalifies
    vbusOverVolt <= 1'b1;
    repeat (3) @(posedge clk);
    chk(converterOn, 1'b0);
    vbusOverVolt <= 1'b0;
    for (int i = 0; i < 400 && converterOn !== 1'b1; i++) @(posedge clk);
    chk(converterOn, 1'b1);
    wr(4'h8, 32'h0);
    chk(wrResp, 2'b10);
    rd(4'h2);
    chk(rdResp, 2'b10);
    stop_test;
  end
endmodule
